// File: verilog/line_framer.sv
// transmit line framer with register file on an AXI4-Lite slave
// assumes all pins synchronous to aclk; receive bits arrive at the local bit rate
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`include "framer_params.svh"
module line_framer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // line side
  input wire logic line_tx_disable_pin,
  input wire logic rx_line_bit,
  input wire logic rx_housekeeping_bit,
  output logic line_out_level,
  output logic line_out_bias,
  // system side
  input wire logic sys_data_in,
  output logic sys_data_out,
  input wire logic ctrl_data_in,
  output logic ctrl_data_out,
  output logic tx_bit_clk,
  output logic channel_delimit_strobe,
  output logic frame_pulse
);
  ////////////////////////////////////////////////////////////////////////////
  framer_pkg::byte_t ctrl_q, diag_q, mode_q, b1_q, b2_q, d_q, cin_q;
  framer_pkg::byte_t b1_s_q, b2_s_q, d_s_q;
  framer_pkg::byte_t eff_ctrl, eff_diag, status;
  logic diag_rst_pend_q;
  logic default_mode, rate_hi, modem_op, master_op, network_terminal_op, slave_op;
  logic dchan_in_bchan, force_out_of_sync, line_tx_mute_bit, housekeeping_bit, mute;
  logic [1:0] loop_sel;

  assign default_mode = &diag_q[`DG_DEF_MSB:`DG_DEF_LSB];
  // default modes clear every option and diagnostic, take the rate from diagnostics bit 3
  assign eff_ctrl = default_mode ? {4'h0, diag_q[`DG_SEL], 3'h0} : ctrl_q;
  assign eff_diag = default_mode ? 8'h00 : diag_q;
  assign rate_hi = eff_ctrl[`CTL_RATE];
  assign dchan_in_bchan = eff_ctrl[`CTL_D_IN_B];
  assign housekeeping_bit = eff_ctrl[`CTL_TXHK];
  assign modem_op = mode_q[`MODE_MODEM];
  assign master_op = mode_q[`MODE_MASTER];
  assign network_terminal_op = ~modem_op;
  assign slave_op = ~master_op;
  assign force_out_of_sync = eff_diag[`DG_UNSYNC];
  assign line_tx_mute_bit = eff_diag[`DG_MUTE];
  assign loop_sel = eff_diag[`DG_LOOP_MSB:`DG_LOOP_LSB];
  assign mute = line_tx_disable_pin | line_tx_mute_bit;

  ////////////////////////////////////////////////////////////////////////////
  // bit timing: half-cell divider, cell enable, frame position
  logic [`HALF_W-1:0] half_cnt_q, half_lim;
  logic phase_q, half_en, bit_en, frame_end;
  logic [`POS_W-1:0] pos_q, frame_len;

  assign half_lim = rate_hi ? `HALF_W'(`HALF_HI - 1) : `HALF_W'(`HALF_LO - 1);
  assign half_en = half_cnt_q >= half_lim;
  assign bit_en = half_en & phase_q;
  assign frame_len = modem_op ? `MODEM_BITS : (rate_hi ? `FRAME_BITS_HI : `FRAME_BITS_LO);
  assign frame_end = bit_en & (pos_q >= frame_len - 5'h01);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_cnt_q <= '0;
      phase_q <= 1'b1;
    end else if (half_en) begin
      half_cnt_q <= '0;
      phase_q <= ~phase_q;
    end else begin
      half_cnt_q <= half_cnt_q + `HALF_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_q <= '0;
    end else if (frame_end) begin
      pos_q <= '0;
    end else if (bit_en) begin
      pos_q <= pos_q + 5'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_pulse <= 1'b0;
      tx_bit_clk <= 1'b0;
    end else begin
      frame_pulse <= frame_end;
      tx_bit_clk <= bit_en;
    end
  end

  // payload for the next frame is latched as the current one ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b1_s_q <= '0;
      b2_s_q <= '0;
      d_s_q <= '0;
    end else if (frame_end) begin
      b1_s_q <= b1_q;
      b2_s_q <= b2_q;
      d_s_q <= d_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame assembly
  framer_pkg::slot_e slot;
  logic [2:0] bidx, sync_idx_q, dptr_q;
  logic use_b2, raw_bit;

  always_comb begin
    slot = framer_pkg::SLOT_B;
    bidx = 3'h0;
    use_b2 = 1'b0;
    if (modem_op) begin
      // continuous stream, no framing bits at all
      use_b2 = pos_q[3];
      bidx = ~pos_q[2:0];
    end else if (!rate_hi) begin
      if (pos_q == 5'h00) begin
        slot = framer_pkg::SLOT_SYNC;
      end else if (pos_q == 5'h01) begin
        slot = framer_pkg::SLOT_D;
      end else begin
        bidx = 3'(5'h09 - pos_q);
      end
    end else begin
      if (pos_q == 5'h00) begin
        slot = framer_pkg::SLOT_SYNC;
      end else if (pos_q == 5'h01) begin
        slot = framer_pkg::SLOT_HOUSE;
      end else if (pos_q < 5'h04) begin
        slot = framer_pkg::SLOT_D;
      end else begin
        use_b2 = pos_q >= 5'h0c;
        bidx = 3'(5'h0b - pos_q);
      end
    end
  end

  always_comb begin
    case (slot)
      framer_pkg::SLOT_SYNC: begin
        raw_bit = 1'(`SYNC_PATTERN >> sync_idx_q) ^ force_out_of_sync;
      end
      framer_pkg::SLOT_HOUSE: raw_bit = housekeeping_bit;
      framer_pkg::SLOT_D: raw_bit = dchan_in_bchan ? 1'b0 : d_s_q[dptr_q];
      framer_pkg::SLOT_B: begin
        if (use_b2) begin
          raw_bit = b2_s_q[bidx];
        end else if (dchan_in_bchan && !modem_op) begin
          raw_bit = d_s_q[bidx];
        end else begin
          raw_bit = b1_s_q[bidx];
        end
      end
      default: raw_bit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_idx_q <= '0;
      dptr_q <= '0;
    end else if (bit_en) begin
      if (slot == framer_pkg::SLOT_SYNC && !modem_op) begin
        sync_idx_q <= sync_idx_q + 3'h1;
      end
      if (slot == framer_pkg::SLOT_D && !modem_op && !dchan_in_bchan) begin
        dptr_q <= dptr_q + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scrambling, coding, receive path and loopbacks
  tx_bit_if bits();
  logic tx_scr, rx_descr;

  scrambler #(.descr(1'b0)) u_scr (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(bit_en),
    .din(raw_bit),
    .dout(tx_scr)
  );

  scrambler #(.descr(1'b1)) u_descr (
    .aclk(aclk),
    .aresetn(aresetn),
    .en(bit_en),
    .din(loop_sel == `LOOP_LINE ? tx_scr : rx_line_bit),
    .dout(rx_descr)
  );

  assign bits.bit_en = bit_en;
  assign bits.half_en = half_en;
  assign bits.data = tx_scr;

  line_coder u_coder (
    .aclk(aclk),
    .aresetn(aresetn),
    .bits(bits),
    .mute(mute),
    .line_level(line_out_level),
    .line_bias(line_out_bias)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_data_out <= 1'b0;
    end else if (bit_en) begin
      sys_data_out <= loop_sel == `LOOP_SYS ? sys_data_in : rx_descr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control channel, one byte per eight bit cells
  logic [2:0] cbit_q;
  framer_pkg::byte_t cout_sh_q, cin_sh_q;

  // housekeeping does not exist in modem operation
  assign status = {modem_op ? 1'b0 : rx_housekeeping_bit, force_out_of_sync, modem_op,
                   rate_hi, default_mode, mute, loop_sel};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cbit_q <= '0;
      cout_sh_q <= '0;
      cin_sh_q <= '0;
      cin_q <= '0;
      ctrl_data_out <= 1'b0;
      channel_delimit_strobe <= 1'b0;
    end else begin
      channel_delimit_strobe <= bit_en & (cbit_q == 3'h0);
      if (bit_en) begin
        cbit_q <= cbit_q + 3'h1;
        if (cbit_q == 3'h0) begin
          ctrl_data_out <= status[7];
          cout_sh_q <= {status[6:0], 1'b0};
        end else begin
          ctrl_data_out <= cout_sh_q[7];
          cout_sh_q <= {cout_sh_q[6:0], 1'b0};
        end
        cin_sh_q <= {cin_sh_q[6:0], ctrl_data_in};
        if (cbit_q == 3'h7) begin
          cin_q <= {cin_sh_q[6:0], ctrl_data_in};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic aw_full_q, w_full_q, do_write;
  logic [`ADDR_W-1:0] aw_addr_q;
  framer_pkg::byte_t w_byte_q;
  logic w_lane_q, wr_hit;

  assign awready = ~aw_full_q & ~bvalid;
  assign wready = ~w_full_q & ~bvalid;
  assign arready = ~rvalid;
  assign do_write = aw_full_q & w_full_q & ~bvalid;
  assign wr_hit = aw_addr_q == `REG_CTRL || aw_addr_q == `REG_DIAG || aw_addr_q == `REG_MODE
                  || aw_addr_q == `REG_B1 || aw_addr_q == `REG_B2 || aw_addr_q == `REG_D;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q <= '0;
      w_lane_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_q <= 1'b1;
        w_byte_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  logic wr_en;
  assign wr_en = do_write & w_lane_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= '0;
      mode_q <= '0;
      b1_q <= '0;
      b2_q <= '0;
      d_q <= '0;
    end else if (wr_en) begin
      if (aw_addr_q == `REG_CTRL) ctrl_q <= w_byte_q;
      if (aw_addr_q == `REG_MODE) mode_q <= w_byte_q;
      if (aw_addr_q == `REG_B1) b1_q <= w_byte_q;
      if (aw_addr_q == `REG_B2) b2_q <= w_byte_q;
      if (aw_addr_q == `REG_D) d_q <= w_byte_q;
    end
  end

  // a pending diagnostics reset fires at the frame pulse; a new request wins over
  // the clear of the pending flag, a diagnostics write wins over the reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag_q <= '0;
      diag_rst_pend_q <= 1'b0;
    end else begin
      if (wr_en && aw_addr_q == `REG_DIAG) begin
        diag_q <= w_byte_q;
      end else if (frame_end && diag_rst_pend_q) begin
        diag_q <= '0;
      end
      if (wr_en && aw_addr_q == `REG_CTRL) begin
        diag_rst_pend_q <= ~w_byte_q[`CTL_DIAG_RST];
      end else if (frame_end) begin
        diag_rst_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      case (araddr)
        `REG_CTRL: rdata <= {24'h0, ctrl_q};
        `REG_DIAG: rdata <= {24'h0, diag_q};
        `REG_STAT: rdata <= {24'h0, status};
        `REG_MODE: rdata <= {24'h0, mode_q};
        `REG_B1: rdata <= {24'h0, b1_q};
        `REG_B2: rdata <= {24'h0, b2_q};
        `REG_D: rdata <= {24'h0, d_q};
        `REG_CIN: rdata <= {24'h0, cin_q};
        default: begin
          rdata <= '0;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// File: verilog/framer_params.svh
// constants for the subscriber line framer: rates, frame layout, register map and fields
// assumes a 10 MHz system clock and one aligned 32-bit word per register
//
// Overview of operation
// - diagnostics bits 4-7 all ones select a default mode chosen by bit 3
// - control write with bit 2 zero clears diagnostics at the next frame pulse
// - status byte plus received housekeeping bit go out on the control channel
// - modem operation makes the control port a plain serial control-only stream
// - modem control bits move on the bit clock, strobe marks channel boundaries
// - differential encoding, output is previous output xor current scrambled bit
// - biphase code, mid-cell rising edge means one, falling means zero
// - line output held at bias when disable pin high or diagnostics bit 6 set outside the default modes
// - 80 kbit/s frame carries sync, one D bit and B1
// - 160 kbit/s frame carries sync, housekeeping, two D bits, B1 and B2
// - with D-in-B set the D channel goes in the B1 timeslot
// - modem operation sends a continuous unframed stream, no sync, housekeeping or D
// - network-terminal operation inserts one bit of the 8-bit sync pattern in every frame
// - default modes run 80 or 160 kbit/s with all options off and housekeeping zero
// - diagnostics bit 4 forces loss of sync by corrupting the sync bit
`ifndef FRAMER_PARAMS_SVH
`define FRAMER_PARAMS_SVH

`define CLK_HZ 10000000
`define RATE_LO_BPS 80000
`define RATE_HI_BPS 160000
`define HALF_LO (`CLK_HZ / (2 * `RATE_LO_BPS))
`define HALF_HI (`CLK_HZ / (2 * `RATE_HI_BPS))
`define HALF_W 7
`define POS_W 5
`define FRAME_BITS_LO 5'h0a
`define FRAME_BITS_HI 5'h14
`define MODEM_BITS 5'h10
`define SYNC_PATTERN 8'h1b
`define SCR_LEN 7
`define SCR_TAP_A 6
`define SCR_TAP_B 5

`define ADDR_W 8
`define REG_CTRL 8'h00
`define REG_DIAG 8'h04
`define REG_STAT 8'h08
`define REG_MODE 8'h0c
`define REG_B1 8'h10
`define REG_B2 8'h14
`define REG_D 8'h18
`define REG_CIN 8'h1c
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CTL_DIAG_RST 2
`define CTL_RATE 3
`define CTL_D_IN_B 4
`define CTL_TXHK 7
`define DG_LOOP_LSB 2
`define DG_LOOP_MSB 3
`define DG_SEL 3
`define DG_UNSYNC 4
`define DG_MUTE 6
`define DG_DEF_LSB 4
`define DG_DEF_MSB 7
`define LOOP_LINE 2'h1
`define LOOP_SYS 2'h2
`define MODE_MODEM 0
`define MODE_MASTER 1

`endif

// File: verilog/framer_pkg.sv
// types shared by the line framer modules
// assumes nothing beyond a SystemVerilog compiler
package framer_pkg;
  typedef enum logic [1:0] {
    SLOT_SYNC = 2'b00,
    SLOT_HOUSE = 2'b01,
    SLOT_D = 2'b10,
    SLOT_B = 2'b11
  } slot_e;
  typedef logic [7:0] byte_t;
endpackage

// File: verilog/tx_bit_if.sv
// bit timing and data handed from the framer to the line coder
// assumes the half-cell enable coincides with the bit enable at cell start
interface tx_bit_if;
  logic bit_en;
  logic half_en;
  logic data;
  modport src(output bit_en, half_en, data);
  modport dst(input bit_en, half_en, data);
endinterface

// File: verilog/scrambler.sv
// self-synchronising scrambler, or descrambler when descr is set
// assumes en is a one-cycle pulse per line bit
`include "framer_params.svh"
module scrambler #(
  parameter bit descr = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bit stream
  input wire logic en,
  input wire logic din,
  output logic dout
);
  logic [`SCR_LEN-1:0] sr_q;
  logic mix;

  assign mix = din ^ sr_q[`SCR_TAP_A] ^ sr_q[`SCR_TAP_B];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_q <= '0;
      dout <= 1'b0;
    end else if (en) begin
      // one input one leaves the all-zero state
      sr_q <= {sr_q[`SCR_LEN-2:0], descr ? din : mix};
      dout <= mix;
    end
  end
endmodule

// File: verilog/line_coder.sv
// differential plus biphase line coder with bias forcing
// assumes bit_en arrives together with half_en at the start of each cell
`include "framer_params.svh"
module line_coder (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bit feed
  tx_bit_if.dst bits,
  input wire logic mute,
  // line
  output logic line_level,
  output logic line_bias
);
  logic diff_q;
  logic diff_d;

  assign diff_d = diff_q ^ bits.data;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diff_q <= 1'b0;
    end else if (bits.bit_en) begin
      diff_q <= diff_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_level <= 1'b0;
    end else if (mute) begin
      line_level <= 1'b0;
    end else if (bits.bit_en) begin
      line_level <= ~diff_d;
    end else if (bits.half_en) begin
      line_level <= diff_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_bias <= 1'b1;
    end else begin
      line_bias <= mute;
    end
  end
endmodule

// File: test/remote_line.sv
// far-end transceiver model: returns a scrambled bit stream and a housekeeping level
// assumes its bit timing follows the transitions it sees on the near-end line
module remote_line (
  // clock
  input wire logic aclk,
  // line from the near end
  input wire logic line_level,
  input wire logic line_bias,
  // housekeeping level commanded by the bench
  input wire logic hk_cmd,
  // line toward the near end
  output logic rx_bit,
  output logic rx_hk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] pat_q = 7'h01;
  logic last_q = 1'b0;
  ////////////////////////////////////////
  // same polynomial as the near end, seeded non-zero so it never sticks
  always @(posedge aclk) begin
    last_q <= line_level;
    if (line_level != last_q && !line_bias) begin
      pat_q <= {pat_q[5:0], pat_q[6] ^ pat_q[5]};
    end
    rx_hk <= hk_cmd;
  end
  assign rx_bit = pat_q[0];
endmodule

// File: test/framer_properties.sv
// properties of the line framer ports: bus handshakes, line coding, bit and frame timing
// assumes it is bound into line_framer and sees only its ports
`include "framer_params.svh"
module framer_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // line and system
  input wire logic line_tx_disable_pin,
  input wire logic line_out_level,
  input wire logic line_out_bias,
  input wire logic tx_bit_clk,
  input wire logic channel_delimit_strobe,
  input wire logic frame_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_both_s; awvalid && awready && wvalid && wready; endsequence
  sequence rd_take_s; arvalid && arready; endsequence
  ////////////////////////////////////////
  write_resp_a: assert property (wr_both_s |-> ##2 bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  read_resp_a: assert property (rd_take_s |=> rvalid && rdata[31:8] == 24'h0)
    else $error("read response late or wide");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  slverr_zero_a: assert property (rvalid && rresp == `RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read returned data");
  bias_force_a: assert property (line_tx_disable_pin [*2] |-> line_out_bias)
    else $error("line not at bias while disabled");
  bias_quiet_a: assert property (line_out_bias |-> !line_out_level)
    else $error("line level driven while at bias");
  half_cell_a: assert property (
    !line_out_bias && $changed(line_out_level) |=> (line_out_bias || $stable(line_out_level)) [*8])
    else $error("line level changed inside a half cell");
  strobe_bit_a: assert property (channel_delimit_strobe |-> tx_bit_clk)
    else $error("channel strobe off the bit clock");
  bit_gap_a: assert property (tx_bit_clk |=> !tx_bit_clk [*8])
    else $error("bit clocks too close");
  frame_bit_a: assert property (frame_pulse |-> tx_bit_clk)
    else $error("frame pulse off the bit clock");
endmodule
bind line_framer framer_checker framer_checker_i (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .rready, .line_tx_disable_pin, .line_out_level, .line_out_bias, .tx_bit_clk,
  .channel_delimit_strobe, .frame_pulse);

// File: test/subscriber_line_framer_codec_test.sv
// bench for the line framer: registers, frame timing, line coding, status channel, modem
// assumes line_framer, its header, the bound checker and the remote line model
`include "framer_params.svh"
module subscriber_line_framer_codec_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hk_cmd;
  logic [`ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, rx_line_bit, rx_housekeeping_bit;
  logic line_tx_disable_pin, line_out_level, line_out_bias, sys_data_in, sys_data_out;
  logic ctrl_data_in, ctrl_data_out, tx_bit_clk, channel_delimit_strobe, frame_pulse;
  int err_count, checks, cycles;
  line_framer line_framer_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .line_tx_disable_pin, .rx_line_bit, .rx_housekeeping_bit,
    .line_out_level, .line_out_bias, .sys_data_in, .sys_data_out, .ctrl_data_in,
    .ctrl_data_out, .tx_bit_clk, .channel_delimit_strobe, .frame_pulse);
  remote_line remote_line_i (.aclk, .line_level(line_out_level), .line_bias(line_out_bias),
    .hk_cmd, .rx_bit(rx_line_bit), .rx_hk(rx_housekeeping_bit));
  ////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    check(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    check(rdata, e);
    check(rresp, er);
  endtask
  // skips a frame so a rate change has settled, then counts bits and cycles
  task automatic frame_len(input int bits, input int gap);
    int n;
    int t;
    n = 0;
    t = 0;
    repeat (2) @(posedge aclk iff frame_pulse);
    do begin
      @(posedge aclk);
      t++;
      if (tx_bit_clk) n++;
    end while (!frame_pulse);
    check(n, bits);
    check(t, bits * gap);
  endtask
  task automatic ctrl_byte(input logic [7:0] e);
    logic [7:0] b;
    repeat (2) @(posedge aclk iff channel_delimit_strobe);
    b = {7'h00, ctrl_data_out};
    repeat (7) begin
      @(posedge aclk iff tx_bit_clk);
      b = {b[6:0], ctrl_data_out};
    end
    check(b, e);
  endtask
  task automatic biphase(input int half);
    logic a;
    repeat (4) begin
      @(posedge aclk iff tx_bit_clk);
      repeat (half / 2) @(posedge aclk);
      a = line_out_level;
      repeat (half) @(posedge aclk);
      check(line_out_level, {31'h0, !a});
    end
  endtask
  ////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      results();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, line_tx_disable_pin} = '0;
    {awaddr, araddr, wdata, sys_data_in, ctrl_data_in} = '0;
    wstrb = 4'h1;
    hk_cmd = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int a = 0; a < 32; a += 4) begin
      if (a != 8) rd(8'(a), 32'h0, `RESP_OKAY);
    end
    wr(`REG_B1, 32'ha5, `RESP_OKAY);
    wstrb <= 4'h0;
    wr(`REG_B1, 32'h5a, `RESP_OKAY);
    wstrb <= 4'h1;
    wr(`REG_B2, 32'hffff_ff3c, `RESP_OKAY);
    rd(`REG_B1, 32'ha5, `RESP_OKAY);
    rd(`REG_B2, 32'h3c, `RESP_OKAY);
    wr(`REG_STAT, 32'h1, `RESP_SLVERR);
    wr(`REG_CIN, 32'h1, `RESP_SLVERR);
    wr(8'h40, 32'h1, `RESP_SLVERR);
    rd(8'h40, 32'h0, `RESP_SLVERR);
    rd(`REG_STAT, 32'h80, `RESP_OKAY);
    frame_len(10, 2 * `HALF_LO);
    wr(`REG_CTRL, 32'h0c, `RESP_OKAY);
    frame_len(20, 2 * `HALF_HI);
    // system loopback with mute and forced loss of sync, never line loopback outside modem operation
    wr(`REG_DIAG, 32'h58, `RESP_OKAY);
    rd(`REG_STAT, 32'hd6, `RESP_OKAY);
    ctrl_byte(8'hd6);
    check(line_out_bias, 1'b1);
    sys_data_in <= 1'b1;
    repeat (2) @(posedge aclk iff tx_bit_clk);
    check(sys_data_out, 1'b1);
    rd(`REG_DIAG, 32'h58, `RESP_OKAY);
    wr(`REG_CTRL, 32'h08, `RESP_OKAY);
    @(posedge aclk iff frame_pulse);
    rd(`REG_DIAG, 32'h0, `RESP_OKAY);
    wr(`REG_DIAG, 32'h58, `RESP_OKAY);
    @(posedge aclk iff frame_pulse);
    rd(`REG_DIAG, 32'h58, `RESP_OKAY);
    wr(`REG_DIAG, 32'h0, `RESP_OKAY);
    biphase(`HALF_HI);
    line_tx_disable_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    check(line_out_bias, 1'b1);
    check(line_out_level, 1'b0);
    line_tx_disable_pin <= 1'b0;
    repeat (3) @(posedge aclk);
    check(line_out_bias, 1'b0);
    wr(`REG_DIAG, 32'hf8, `RESP_OKAY);
    rd(`REG_STAT, 32'h98, `RESP_OKAY);
    frame_len(20, 2 * `HALF_HI);
    wr(`REG_DIAG, 32'hf0, `RESP_OKAY);
    rd(`REG_DIAG, 32'hf0, `RESP_OKAY);
    rd(`REG_STAT, 32'h88, `RESP_OKAY);
    frame_len(10, 2 * `HALF_LO);
    wr(`REG_DIAG, 32'h0, `RESP_OKAY);
    wr(`REG_B1, 32'hff, `RESP_OKAY);
    wr(`REG_MODE, 32'h1, `RESP_OKAY);
    rd(`REG_STAT, 32'h30, `RESP_OKAY);
    ctrl_data_in <= 1'b1;
    ctrl_byte(8'h30);
    rd(`REG_CIN, 32'hff, `RESP_OKAY);
    frame_len(16, 2 * `HALF_HI);
    // line loopback in modem master operation: an all-ones stream comes back as ones
    sys_data_in <= 1'b0;
    wr(`REG_B2, 32'hff, `RESP_OKAY);
    wr(`REG_MODE, 32'h3, `RESP_OKAY);
    wr(`REG_DIAG, 32'h04, `RESP_OKAY);
    repeat (2) @(posedge aclk iff frame_pulse);
    check(sys_data_out, 1'b1);
    results();
  end
endmodule
